// ==== hdl/tx_decode_regs.svh ====
// Opcodes, field codes, flag positions and cycle counts for the test/xor/trap unit
`ifndef TX_DECODE_REGS_SVH
`define TX_DECODE_REGS_SVH

// ==========================================================
// Opcode groups
`define OPC_TEST_HI   4'h7
`define OPC_XOR_HI    4'hb
`define OPC_TRAP      8'hf2

// ==========================================================
// Low nibble: operand field forms
`define LO_W_W        4'h2
`define LO_W_IW       4'h3
`define LO_R_R        4'h4
`define LO_R_PTR      4'h5
`define LO_R_LIT      4'h6
`define LO_PTR_LIT    4'h7
`define LO_L_L        4'h8
`define LO_L_LIT      4'h9

// ==========================================================
// Instruction cycle counts
`define CYC_SHORT     3'h3
`define CYC_LONG      3'h4
`define CYC_TRAP      3'h6
`define CNT_FIRST     3'h1
`define CNT_STEP      3'h1

// ==========================================================
// Trap micro-steps, counted from the first busy cycle
`define TRAP_WR_HI    3'h1
`define TRAP_WR_FLG   3'h2
`define TRAP_RD_HI    3'h3
`define TRAP_RD_LO    3'h4
`define TRAP_PC_LD    3'h5

// ==========================================================
// Flag byte positions
`define FLAG_C        7
`define FLAG_Z        6
`define FLAG_S        5
`define FLAG_V        4

// ==========================================================
// Stack and address padding
`define SP_PC_BYTES   16'h0002
`define SP_FLG_BYTES  16'h0001
`define SP_ONE        16'h0001
`define VEC_PAD       7'h00
`define VEC_LO_BIT    1'h1
`define VEC_HI_BIT    1'h0
`define ZERO_BYTE     8'h00

`endif

// ==== hdl/tx_decode_pkg.sv ====
// Types shared by the test/xor/trap unit
package tx_decode_pkg;

    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PTR  = 6'h02,
        ST_SRC  = 6'h04,
        ST_DST  = 6'h08,
        ST_WAIT = 6'h10,
        ST_TRAP = 6'h20
    } fsm_t;

    // ==========================================================
    // Address space of a bus access
    typedef enum logic [1:0] {
        SPACE_REG  = 2'h0,
        SPACE_DATA = 2'h1,
        SPACE_CODE = 2'h2
    } space_t;

    // ==========================================================
    // Whole state of the sequencer
    typedef struct packed {
        fsm_t        fsm;
        logic [2:0]  cnt;
        logic [2:0]  ncyc;
        logic        use_xor;
        logic        is_trap;
        logic        ptr_src;
        logic [11:0] dst_addr;
        logic [7:0]  src;
        logic [7:0]  vec;
        logic [15:0] bus_addr;
        space_t      bus_space;
        logic        bus_rd;
        logic        bus_wr;
        logic [7:0]  bus_wdata;
        logic [7:0]  result;
        logic [7:0]  flags;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] disp;
    } state_t;

endpackage

// ==== hdl/logic_flag_unit.sv ====
// AND / exclusive-OR result and flag function
`timescale 1ns/10ps
`include "tx_decode_regs.svh"

module logic_flag_unit (
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       use_xor,
    input  wire logic [7:0] flags_in,
    output logic      [7:0] result,
    output logic      [7:0] flags_out
);

    // ==========================================================
    // Result and flags; carry, decimal-adjust, half-carry pass through
    always_comb begin
        result                = use_xor ? (a ^ b) : (a & b);
        flags_out             = flags_in;
        flags_out[`FLAG_Z]    = (result == `ZERO_BYTE);
        flags_out[`FLAG_S]    = result[7];
        flags_out[`FLAG_V]    = 1'b0;
    end

endmodule

// ==== hdl/test_xor_trap_decode.sv ====
// Sequencer for test-under-mask, exclusive-OR and trap instructions
`timescale 1ns/10ps
`include "tx_decode_regs.svh"

// Notes on behaviour
// - Opcodes 72-77 AND operands, drop result, set Z/S, clear V, keep C/D/H.
// - Opcodes 78/79 use long addresses, four bytes, three cycles, plain flags.
// - Opcodes B2-B7 write dst XOR src back, set Z/S, clear V.
// - Opcodes B8/B9 write XOR to long address, four bytes, three cycles.
// - F2 pushes PC then flags, loads PC from vector, six cycles, flags kept.
// - Index or displacement field is an 8-bit signed two's-complement value.
// - Working register is 4-bit selector in group; full register is 8-bit.
// - Result flags computed, cleared flags zero, unaffected flags retained.
module test_xor_trap_decode #(
    parameter int REG_AW = 12
) (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic                  start,
    input  wire logic [7:0]            opcode,
    input  wire logic [7:0]            op1,
    input  wire logic [7:0]            op2,
    input  wire logic [7:0]            op3,
    input  wire logic [7:0]            rp,
    input  wire logic [15:0]           pc_in,
    input  wire logic [15:0]           sp_in,
    input  wire logic [7:0]            flags_in,
    input  wire logic [7:0]            bus_rdata,
    output logic                       claimed,
    output logic                       busy,
    output logic                       done,
    output logic [15:0]                bus_addr,
    output tx_decode_pkg::space_t      bus_space,
    output logic                       bus_rd,
    output logic                       bus_wr,
    output logic [7:0]                 bus_wdata,
    output logic [7:0]                 flags_out,
    output logic                       flags_we,
    output logic [15:0]                pc_out,
    output logic                       pc_we,
    output logic [15:0]                sp_out,
    output logic                       sp_we,
    output logic [15:0]                disp_target
);

    // ==========================================================
    // Elaboration check: operand fields are fixed at a 12-bit file
    if (REG_AW != 12) begin : g_bad_width
        $error("register address width must be 12");
    end

    localparam tx_decode_pkg::state_t RESET_ST = '{
        fsm: tx_decode_pkg::ST_IDLE, bus_space: tx_decode_pkg::SPACE_REG, default: '0};

    tx_decode_pkg::state_t st_q;
    tx_decode_pkg::state_t st_d;
    logic [7:0]            lu_result;
    logic [7:0]            lu_flags;
    logic [3:0]            lo;
    logic                  supported;
    logic                  src_ind;
    logic                  dst_ind;
    logic                  src_lit;
    logic [11:0]           dst_a;
    logic [11:0]           src_a;
    logic [7:0]            lit;

    // ==========================================================
    // Address helpers
    function automatic logic [11:0] work_addr(input logic [7:0] ptr, input logic [3:0] sel);
        work_addr = {ptr[3:0], ptr[7:4], sel};
    endfunction

    function automatic logic [11:0] full_addr(input logic [7:0] ptr, input logic [7:0] reg8);
        full_addr = {ptr[3:0], reg8};
    endfunction

    function automatic logic [15:0] reg_bus(input logic [11:0] a);
        reg_bus = {{(16 - REG_AW){1'b0}}, a};
    endfunction

    function automatic logic [15:0] sext8(input logic [7:0] d);
        sext8 = {{8{d[7]}}, d};
    endfunction

    // ==========================================================
    // Operand field decode of the opcode presented with start
    always_comb begin
        lo        = opcode[3:0];
        supported = (opcode == `OPC_TRAP) ||
                    (((opcode[7:4] == `OPC_TEST_HI) || (opcode[7:4] == `OPC_XOR_HI)) &&
                     (lo >= `LO_W_W) && (lo <= `LO_L_LIT));
        src_ind   = (lo == `LO_W_IW) || (lo == `LO_R_PTR);
        dst_ind   = (lo == `LO_PTR_LIT);
        src_lit   = (lo == `LO_R_LIT) || (lo == `LO_PTR_LIT) || (lo == `LO_L_LIT);
        lit       = (lo == `LO_L_LIT) ? op1 : op2;
        case (lo)
            `LO_W_W, `LO_W_IW: begin
                dst_a = work_addr(rp, op1[7:4]);
                src_a = work_addr(rp, op1[3:0]);
            end
            `LO_R_R, `LO_R_PTR: begin
                dst_a = full_addr(rp, op2);
                src_a = full_addr(rp, op1);
            end
            `LO_L_L, `LO_L_LIT: begin
                dst_a = {op2[3:0], op3};
                src_a = {op1, op2[7:4]};
            end
            default: begin
                dst_a = full_addr(rp, op1);
                src_a = full_addr(rp, op1);
            end
        endcase
    end

    logic_flag_unit u_lfu (
        .a         (bus_rdata),
        .b         (st_q.src),
        .use_xor   (st_q.use_xor),
        .flags_in  (st_q.flags),
        .result    (lu_result),
        .flags_out (lu_flags)
    );

    // ==========================================================
    // Handshake outputs; bus accesses are issued one cycle ahead
    assign busy        = (st_q.fsm != tx_decode_pkg::ST_IDLE);
    assign claimed     = start && supported && !busy;
    assign done        = busy && (st_q.cnt == st_q.ncyc);
    assign flags_we    = done && !st_q.is_trap;
    assign pc_we       = done && st_q.is_trap;
    assign sp_we       = done && st_q.is_trap;
    assign bus_addr    = st_q.bus_addr;
    assign bus_space   = st_q.bus_space;
    assign bus_rd      = st_q.bus_rd;
    assign bus_wr      = st_q.bus_wr;
    assign bus_wdata   = st_q.bus_wdata;
    assign flags_out   = st_q.flags;
    assign pc_out      = st_q.pc;
    assign sp_out      = st_q.sp;
    assign disp_target = st_q.disp;

    // ==========================================================
    // Next state; strobes fall back to idle unless a step asks again
    always_comb begin
        st_d        = st_q;
        st_d.bus_rd = 1'b0;
        st_d.bus_wr = 1'b0;
        if (busy) begin
            st_d.cnt = st_q.cnt + `CNT_STEP;
        end
        case (st_q.fsm)
            tx_decode_pkg::ST_IDLE: begin
                if (claimed) begin
                    st_d.cnt       = `CNT_FIRST;
                    st_d.use_xor   = (opcode[7:4] == `OPC_XOR_HI);
                    st_d.is_trap   = (opcode == `OPC_TRAP);
                    st_d.flags     = flags_in;
                    st_d.dst_addr  = dst_a;
                    st_d.ptr_src   = src_ind;
                    st_d.disp      = pc_in + sext8(op1);
                    st_d.bus_rd    = 1'b1;
                    st_d.bus_space = tx_decode_pkg::SPACE_REG;
                    st_d.ncyc      = (src_ind || dst_ind) ? `CYC_LONG : `CYC_SHORT;
                    if (opcode == `OPC_TRAP) begin
                        // PC low byte sits above the high byte on the stack
                        st_d.ncyc      = `CYC_TRAP;
                        st_d.vec       = op1;
                        st_d.sp        = sp_in - `SP_PC_BYTES - `SP_FLG_BYTES;
                        st_d.bus_rd    = 1'b0;
                        st_d.bus_wr    = 1'b1;
                        st_d.bus_space = tx_decode_pkg::SPACE_DATA;
                        st_d.bus_addr  = sp_in - `SP_ONE;
                        st_d.bus_wdata = pc_in[7:0];
                        st_d.pc        = pc_in;
                        st_d.fsm       = tx_decode_pkg::ST_TRAP;
                    end else if (dst_ind) begin
                        // Pointer destination still takes its literal source
                        st_d.src      = lit;
                        st_d.bus_addr = reg_bus(dst_a);
                        st_d.fsm      = tx_decode_pkg::ST_PTR;
                    end else if (src_ind) begin
                        st_d.bus_addr = reg_bus(src_a);
                        st_d.fsm      = tx_decode_pkg::ST_PTR;
                    end else if (src_lit) begin
                        st_d.src      = lit;
                        st_d.bus_addr = reg_bus(dst_a);
                        st_d.fsm      = tx_decode_pkg::ST_DST;
                    end else begin
                        st_d.bus_addr = reg_bus(src_a);
                        st_d.fsm      = tx_decode_pkg::ST_SRC;
                    end
                end
            end
            tx_decode_pkg::ST_PTR: begin
                // Pointer held in a register names a full 8-bit register
                st_d.bus_rd = 1'b1;
                if (st_q.ptr_src) begin
                    st_d.bus_addr = reg_bus(full_addr(rp, bus_rdata));
                    st_d.fsm      = tx_decode_pkg::ST_SRC;
                end else begin
                    st_d.dst_addr = full_addr(rp, bus_rdata);
                    st_d.bus_addr = reg_bus(full_addr(rp, bus_rdata));
                    st_d.fsm      = tx_decode_pkg::ST_DST;
                end
            end
            tx_decode_pkg::ST_SRC: begin
                st_d.src      = bus_rdata;
                st_d.bus_rd   = 1'b1;
                st_d.bus_addr = reg_bus(st_q.dst_addr);
                st_d.fsm      = tx_decode_pkg::ST_DST;
            end
            tx_decode_pkg::ST_DST: begin
                st_d.result = lu_result;
                st_d.flags  = lu_flags;
                st_d.fsm    = tx_decode_pkg::ST_WAIT;
                // Test form discards its result: no write-back
                if (st_q.use_xor) begin
                    st_d.bus_wr    = 1'b1;
                    st_d.bus_addr  = reg_bus(st_q.dst_addr);
                    st_d.bus_wdata = lu_result;
                end
            end
            tx_decode_pkg::ST_WAIT: begin
                if (done) begin
                    st_d.fsm = tx_decode_pkg::ST_IDLE;
                end
            end
            tx_decode_pkg::ST_TRAP: begin
                // Flags are stored, never altered, by the trap
                case (st_q.cnt)
                    `TRAP_WR_HI: begin
                        st_d.bus_wr    = 1'b1;
                        st_d.bus_addr  = st_q.sp + `SP_FLG_BYTES;
                        st_d.bus_wdata = st_q.pc[15:8];
                    end
                    `TRAP_WR_FLG: begin
                        st_d.bus_wr    = 1'b1;
                        st_d.bus_addr  = st_q.sp;
                        st_d.bus_wdata = st_q.flags;
                    end
                    `TRAP_RD_HI: begin
                        st_d.bus_rd    = 1'b1;
                        st_d.bus_space = tx_decode_pkg::SPACE_CODE;
                        st_d.bus_addr  = {`VEC_PAD, st_q.vec, `VEC_HI_BIT};
                    end
                    `TRAP_RD_LO: begin
                        st_d.pc[15:8] = bus_rdata;
                        st_d.bus_rd   = 1'b1;
                        st_d.bus_addr = {`VEC_PAD, st_q.vec, `VEC_LO_BIT};
                    end
                    `TRAP_PC_LD: begin
                        st_d.pc[7:0] = bus_rdata;
                    end
                    default: begin
                        if (done) begin
                            st_d.fsm = tx_decode_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
            default: begin
                st_d = RESET_ST;
            end
        endcase
    end

    // ==========================================================
    // State register, synchronous reset
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= RESET_ST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Checks and covers
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_test_no_write: assert property (
        claimed && (opcode[7:4] == `OPC_TEST_HI) |=> !bus_wr [*4])
        else $error("test-under-mask wrote its destination");

    a_test_long_cycles: assert property (
        claimed && (opcode[7:4] == `OPC_TEST_HI) && (opcode[3:0] >= `LO_L_L) |-> ##3 (done && flags_we))
        else $error("long test-under-mask not three cycles");

    a_xor_write_back: assert property (
        claimed && (opcode[7:4] == `OPC_XOR_HI) && (opcode[3:0] < `LO_L_L)
        |-> ##[2:4] (bus_wr && (bus_space == tx_decode_pkg::SPACE_REG) &&
                     (bus_wdata == ($past(bus_rdata) ^ $past(st_q.src)))))
        else $error("exclusive-OR result not written back");

    a_xor_long_timing: assert property (
        claimed && (opcode[7:4] == `OPC_XOR_HI) && (opcode[3:0] >= `LO_L_L)
        |-> ##[2:3] bus_wr ##[0:1] done)
        else $error("long exclusive-OR not written in three cycles");

    a_trap_six_cycles: assert property (
        claimed && (opcode == `OPC_TRAP)
        |=> !done [*5] ##1 (done && pc_we && sp_we && !flags_we))
        else $error("trap did not finish in six cycles");

    a_trap_vector_read: assert property (
        claimed && (opcode == `OPC_TRAP)
        |-> ##4 (bus_rd && (bus_space == tx_decode_pkg::SPACE_CODE) &&
                 (bus_addr == {`VEC_PAD, $past(op1, 4), `VEC_HI_BIT})))
        else $error("trap vector not read from program space");

    a_trap_stack: assert property (
        claimed && (opcode == `OPC_TRAP)
        |=> (bus_wr && (bus_addr == $past(sp_in) - `SP_ONE) && (bus_wdata == $past(pc_in[7:0]))))
        else $error("trap pushed PC low byte to wrong place");

    a_disp_signed: assert property (
        claimed |=> (disp_target == $past(pc_in) + {{8{$past(op1[7])}}, $past(op1)}))
        else $error("displacement not sign-extended");

    a_work_reg_addr: assert property (
        claimed && (opcode[3:0] == `LO_W_W) && (opcode != `OPC_TRAP)
        |=> (bus_addr[11:0] == {$past(rp[3:0]), $past(rp[7:4]), $past(op1[3:0])}))
        else $error("working register selector decoded wrongly");

    a_flag_rules: assert property (
        flags_we |-> (!flags_out[`FLAG_V] && (flags_out[`FLAG_S] == st_q.result[7]) &&
                      (flags_out[`FLAG_Z] == (st_q.result == `ZERO_BYTE))))
        else $error("flag update wrong");

    a_carry_kept: assert property (
        claimed && (opcode != `OPC_TRAP) |=> (flags_out[`FLAG_C] == $past(flags_in[`FLAG_C])))
        else $error("carry flag not retained");

    c_test_done: cover property (claimed && (opcode[7:4] == `OPC_TEST_HI) ##[3:4] done);
    c_xor_done:  cover property (claimed && (opcode[7:4] == `OPC_XOR_HI) ##[3:4] done);
    c_long_done: cover property (claimed && (opcode[3:0] == `LO_L_LIT) ##3 done);
    c_trap_done: cover property (claimed && (opcode == `OPC_TRAP) ##6 pc_we);

endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the test/xor/trap sequencer
`timescale 1ns/10ps

module tb;
    // ==========================================================
    // Signals, counters and expectation queues
    logic                  clock;
    logic                  reset_n;
    logic                  start;
    logic [7:0]            opcode;
    logic [7:0]            op1;
    logic [7:0]            op2;
    logic [7:0]            op3;
    logic [7:0]            rp;
    logic [15:0]           pc_in;
    logic [15:0]           sp_in;
    logic [7:0]            flags_in;
    logic [7:0]            bus_rdata;
    logic                  claimed;
    logic                  busy;
    logic                  done;
    logic [15:0]           bus_addr;
    tx_decode_pkg::space_t bus_space;
    logic                  bus_rd;
    logic                  bus_wr;
    logic [7:0]            bus_wdata;
    logic [7:0]            flags_out;
    logic                  flags_we;
    logic [15:0]           pc_out;
    logic                  pc_we;
    logic [15:0]           sp_out;
    logic                  sp_we;
    logic [15:0]           disp_target;
    int                    mismatches;
    int                    compares;
    int                    cyc;
    logic                  seen;
    logic [31:0]           seed;
    logic [7:0]            last_f;
    logic [25:0]           wr_q[$];
    logic [7:0]            fl_q[$];
    logic [39:0]           pc_q[$];
    logic [2:0]            n_q[$];
    logic [15:0]           d_q[$];
    logic [7:0]            tbl[17] = '{8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
                                       8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hf2};
    logic [7:0]            bad_ops[6] = '{8'h71, 8'h7a, 8'hb1, 8'hba, 8'hf3, 8'h5f};

    test_xor_trap_decode #(.REG_AW(12)) test_xor_trap_decode_inst (
        .clock(clock), .reset_n(reset_n), .start(start), .opcode(opcode), .op1(op1), .op2(op2),
        .op3(op3), .rp(rp), .pc_in(pc_in), .sp_in(sp_in), .flags_in(flags_in), .bus_rdata(bus_rdata),
        .claimed(claimed), .busy(busy), .done(done), .bus_addr(bus_addr), .bus_space(bus_space),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .flags_out(flags_out),
        .flags_we(flags_we), .pc_out(pc_out), .pc_we(pc_we), .sp_out(sp_out), .sp_we(sp_we),
        .disp_target(disp_target)
    );

    // ==========================================================
    // Memory model: contents are a fixed function of address and space,
    // so a wrong address shows up as a wrong result
    function automatic logic [7:0] mem(input logic [15:0] a, input logic [1:0] s);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ {s, 6'h2b};
    endfunction

    function automatic logic [7:0] rm(input logic [11:0] a);
        return mem({4'h0, a}, 2'h0);
    endfunction

    function automatic logic [11:0] wa(input logic [3:0] s);
        return {rp[3:0], rp[7:4], s};
    endfunction

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed[7:0];
    endfunction

    assign bus_rdata = mem(bus_addr, bus_space);

    // ==========================================================
    // Compare and verdict
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bounded wait on a flag sampled at the falling edge
    task automatic wait_flag(input bit want_done);
        int k;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while ((want_done ? done : claimed) !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            close_out();
        end
    endtask

    // ==========================================================
    // Driver: present one instruction and note what it must produce
    task automatic run_op(input logic [7:0] opc, input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] c);
        logic [11:0] s_ad;
        logic [11:0] d_ad;
        logic [7:0]  sv;
        logic [7:0]  r;
        logic [7:0]  lit;
        logic [15:0] sp;
        @(posedge clock);
        #1;
        opcode   = opc;
        op1      = a;
        op2      = b;
        op3      = c;
        rp       = rnd();
        pc_in    = {rnd(), rnd()};
        sp_in    = {rnd(), rnd()};
        flags_in = rnd();
        sp       = sp_in;
        start    = 1'b1;
        d_q.push_back(pc_in + {{8{a[7]}}, a});
        if (opc == 8'hf2) begin
            n_q.push_back(3'h6);
            wr_q.push_back({2'h1, sp - 16'h1, pc_in[7:0]});
            wr_q.push_back({2'h1, sp - 16'h2, pc_in[15:8]});
            wr_q.push_back({2'h1, sp - 16'h3, flags_in});
            pc_q.push_back({mem({7'h0, a, 1'b0}, 2'h2), mem({7'h0, a, 1'b1}, 2'h2), sp - 16'h3, flags_in});
        end else begin
            lit = b;
            case (opc[3:0])
                4'h2: begin s_ad = wa(a[3:0]); d_ad = wa(a[7:4]); end
                4'h3: begin s_ad = {rp[3:0], rm(wa(a[3:0]))}; d_ad = wa(a[7:4]); end
                4'h4: begin s_ad = {rp[3:0], a}; d_ad = {rp[3:0], b}; end
                4'h5: begin s_ad = {rp[3:0], rm({rp[3:0], a})}; d_ad = {rp[3:0], b}; end
                4'h6: begin s_ad = 12'h0; d_ad = {rp[3:0], a}; end
                4'h7: begin s_ad = 12'h0; d_ad = {rp[3:0], rm({rp[3:0], a})}; end
                4'h8: begin s_ad = {a, b[7:4]}; d_ad = {b[3:0], c}; end
                default: begin s_ad = 12'h0; d_ad = {b[3:0], c}; lit = a; end
            endcase
            sv     = (opc[3:0] inside {4'h6, 4'h7, 4'h9}) ? lit : rm(s_ad);
            r      = (opc[7:4] == 4'hb) ? (rm(d_ad) ^ sv) : (rm(d_ad) & sv);
            last_f = {flags_in[7], r == 8'h0, r[7], 1'b0, flags_in[3:0]};
            fl_q.push_back(last_f);
            if (opc[7:4] == 4'hb) begin
                wr_q.push_back({2'h0, 4'h0, d_ad, r});
            end
            n_q.push_back((opc[3:0] inside {4'h3, 4'h5, 4'h7}) ? 3'h4 : 3'h3);
        end
        wait_flag(1'b0);
        // Start stays high through the run so a second claim would show
        wait_flag(1'b1);
    endtask

    // Unsupported opcode from idle must never be taken
    task automatic refuse(input logic [7:0] opc);
        @(posedge clock);
        #1;
        opcode = opc;
        start  = 1'b1;
        repeat (3) begin
            @(negedge clock);
            chk("refused op", 40'h0, {claimed, busy});
        end
        @(posedge clock);
        #1;
        start = 1'b0;
    endtask

    // ==========================================================
    // Watcher: every result takes the oldest note of its kind
    always @(negedge clock) begin
        if (reset_n === 1'b1) begin
            if (claimed === 1'b1) begin
                chk("claim while busy", 40'h0, seen);
                seen = 1'b1;
                cyc  = 0;
            end else if (seen) begin
                cyc++;
            end
            if (seen && cyc == 1) chk("disp target", d_q.pop_front(), disp_target);
            if (bus_wr === 1'b1) chk("bus write", wr_q.size() ? wr_q.pop_front() : 26'h0,
                                     {bus_space, bus_addr, bus_wdata});
            if (flags_we === 1'b1) chk("flags", fl_q.size() ? fl_q.pop_front() : 8'hxx, flags_out);
            if (pc_we === 1'b1) chk("trap pc sp", pc_q.size() ? pc_q.pop_front() : 40'h0,
                                    {pc_out, sp_out, flags_out});
            if (pc_we === 1'b1) chk("sp write", 40'h1, sp_we);
            if (done === 1'b1) begin
                chk("cycles", n_q.size() ? n_q.pop_front() : 3'h0, cyc[2:0]);
                seen = 1'b0;
            end
        end
    end

    // ==========================================================
    // Clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ==========================================================
    // Main sequence
    initial begin
        reset_n    = 1'b0;
        {start, opcode, op1, op2, op3, rp, pc_in, sp_in, flags_in} = '0;
        mismatches = 0;
        compares   = 0;
        seen       = 1'b0;
        cyc        = 0;
        last_f     = 8'h00;
        seed       = 32'h72fdd550;
        repeat (8) @(posedge clock);
        #1;
        reset_n = 1'b1;
        @(negedge clock);
        chk("reset state", 40'h0, {busy, done, bus_wr, flags_out, pc_out, sp_out});
        foreach (bad_ops[i]) refuse(bad_ops[i]);
        // Results of zero: same register on both sides of an exclusive-OR; then a trap with vector 80
        run_op(8'hb2, 8'h55, 8'h00, 8'h00);
        run_op(8'hb8, 8'h75, 8'h67, 8'h56);
        run_op(8'hf2, 8'h80, 8'h00, 8'h00);
        // Every opcode back to back, random operands
        for (int n = 0; n < 4; n++) begin
            foreach (tbl[i]) run_op(tbl[i], rnd(), rnd(), rnd());
        end
        @(posedge clock);
        #1;
        start = 1'b0;
        repeat (4) @(posedge clock);
        chk("leftover notes", 40'h0, wr_q.size() + fl_q.size() + pc_q.size() + n_q.size());
        close_out();
    end
endmodule
